// [async_isosync_serial_port_regs.vh]
/*
  Register map, field positions, reset values and timing counts for the
  async/isosync serial port. Assumes a 32-bit Avalon-MM slave with byte
  addresses; only the low data lanes carry register bits.
*/
`ifndef ASYNC_ISOSYNC_SERIAL_PORT_REGS_VH
`define ASYNC_ISOSYNC_SERIAL_PORT_REGS_VH

// byte offsets
`define OFS_FRAME_FORMAT   5'h00
`define OFS_PORT_CONTROL   5'h04
`define OFS_DIVISOR_UPPER  5'h08
`define OFS_DIVISOR_LOWER  5'h0c
`define OFS_CLOCK_PIN_CTL  5'h10
`define OFS_TRANSMIT_BUF   5'h14
`define OFS_RECEIVE_BUF    5'h18
`define OFS_STATUS         5'h1c

// frame_format_register fields
`define FMT_LEN_HI         2
`define FMT_LEN_LO         0
`define FMT_ADDR_MODE      3
`define FMT_ISO_MODE       4
`define FMT_PAR_EN         5
`define FMT_PAR_EVEN       6
`define FMT_TWO_STOP       7

// port_control_register fields
`define CTL_RX_EN          0
`define CTL_TX_EN          1
`define CTL_TX_WAKE        3
`define CTL_INT_CLK        4
`define CTL_SOFT_RESET_N   5
`define CTL_RX_INT_EN      6

// clock_pin_control_register fields
`define PIN_DIR            0
`define PIN_DATA_IN        1
`define PIN_DATA_OUT       2
`define PIN_FUNCTION       3

// status register fields
`define ST_TX_READY        0
`define ST_TX_EMPTY        1
`define ST_RX_READY        2
`define ST_RX_ERROR        3
`define ST_PARITY_ERR      4
`define ST_FRAMING_ERR     5
`define ST_OVERRUN_ERR     6
`define ST_BREAK_ERR       7
`define ST_RX_WAKE         8

// reset values
`define RST_FRAME_FORMAT   8'h07
`define RST_PORT_CONTROL   8'h00
`define RST_DIVISOR_UPPER  8'h00
`define RST_DIVISOR_LOWER  8'h00
`define RST_CLOCK_PIN_CTL  4'h0

// timing counts
`define ASYNC_TICKS_LAST   4'hf
`define ASYNC_MID_TICK     4'h7
`define BLANK_BITS_LAST    4'h9
`define IDLE_BITS_ISO      8'h0a
`define IDLE_TICKS_ASYNC   8'ha0

`endif

// [async_isosync_serial_port.v]
/*
  Full-duplex serial port, asynchronous (16 shift clocks per bit) and
  isosynchronous (1 shift clock per bit), with an Avalon-MM register slave.
  Assumes a single 40 MHz clock; receive data and the clock pin come from
  outside and are synchronised here.
*/
// Summary of operation
// (R1) soft reset bit at 0 clears all operating flags and halts both state machines
// (R2) soft reset bit at 1 lets transmission and reception run
// (R3) software should configure while in soft reset, may release in same write
// (R4) asynchronous mode holds every transmitted bit for sixteen shift clocks
// (R5) isosynchronous mode shifts one bit per shift clock, same frame format
// (R6) isosynchronous shift clock is internal and driven out, or external input
// (R7) clock pin function zero: pin is GPIO under direction and data bits
// (R8) clock pin function one: pin carries shift clock, GPIO bits ignored
// (R9) divisor is sixteen bits from upper and lower byte registers
// (R10) async bit rate is system clock over 32 times divisor plus one
// (R11) iso internal bit rate is system clock over 2 times divisor plus one
// (R12) external shift clock must not exceed one tenth of system clock
// (R13) both link ends must use identical async bit rates
// (R14) async reception starts on a falling edge of the receive line; iso reception starts on a tick with the line low
// (R15) after programmed bits, copy shift register to buffer and set ready
// (R16) receive ready with receive interrupt enabled raises interrupt request
// (R17) parity, framing, overrun, break set own flag and summary; keep receiving
// (R18) multiprocessor receiver marks each frame address or data in wake status
// (R19) transmit buffer write clears transmit ready
// (R20) empty shift register takes buffered character and sets transmit ready
// (R21) wake bit copied to hidden staging bit with character; neither writable; port control writes still set the wake bit here
// (R22) idle-line mode with wake set sends ten idle bit times instead of data
// (R23) three-bit length selects 1..8 bits, right-justified, LSB first
// (R24) control bit selects address-bit protocol or idle-line protocol
// (R25) two bits enable parity and choose odd or even
// (R26) one low start bit, one or two high stop bits, idle high
// (R27) async receiver samples mid-bit, rejects start not low at mid-bit
// (R28) transmit starts only when enabled and released; line idles high
`timescale 1ns/1ps
`default_nettype none
`include "async_isosync_serial_port_regs.vh"

module async_isosync_serial_port (
  input  wire        mclk_in,
  input  wire        sys_rst_in,
  input  wire [4:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  input  wire [3:0]  avs_byteenable_in,
  output wire [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  input  wire        rxd_in,
  output wire        txd_out,
  input  wire        sclk_pin_in,
  output wire        sclk_pin_out,
  output wire        sclk_pin_oe_out,
  output wire        rx_irq_out
);

  localparam T_IDLE  = 3'd0;
  localparam T_START = 3'd1;
  localparam T_DATA  = 3'd2;
  localparam T_ADDR  = 3'd3;
  localparam T_PAR   = 3'd4;
  localparam T_STOP  = 3'd5;
  localparam T_BLANK = 3'd6;

  localparam R_IDLE  = 3'd0;
  localparam R_START = 3'd1;
  localparam R_DATA  = 3'd2;
  localparam R_ADDR  = 3'd3;
  localparam R_PAR   = 3'd4;
  localparam R_STOP  = 3'd5;

  // right-justified mask for a character of len+1 bits
  function [7:0] len_mask;
    input [2:0] len;
    begin
      len_mask = 8'hff >> (3'd7 - len); // [R23]
    end
  endfunction

  // parity bit that makes the total count odd or even
  function par_bit;
    input [7:0] data;
    input [2:0] len;
    input       even;
    begin
      par_bit = (^(data & len_mask(len))) ^ ~even; // [R25]
    end
  endfunction

  reg  [7:0]  fmt_q;
  reg  [7:0]  ctl_q;
  reg  [7:0]  div_hi_q;
  reg  [7:0]  div_lo_q;
  reg  [3:0]  pinctl_q;
  reg  [7:0]  tx_buf_q;
  reg         ack_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;

  reg         rxd_s1_q;
  reg         rxd_s2_q;
  reg         rxd_prev_q;
  reg         sclk_s1_q;
  reg         sclk_s2_q;
  reg         sclk_prev_q;

  reg  [15:0] div_cnt_q;
  reg         sclk_int_q;
  reg         sclk_out_q;
  reg         sclk_oe_q;

  reg  [2:0]  tx_st_q;
  reg  [3:0]  tx_tcnt_q;
  reg  [3:0]  tx_bit_q;
  reg  [7:0]  tx_shf_q;
  reg         wut_q;
  reg         tx_par_q;
  reg         tx_full_q;
  reg         txd_q;
  reg         txd_d;

  reg  [2:0]  rx_st_q;
  reg  [3:0]  rx_tcnt_q;
  reg  [2:0]  rx_bit_q;
  reg  [7:0]  rx_shf_q;
  reg         rx_abit_q;
  reg         rx_pbit_q;
  reg         rx_zero_q;
  reg  [7:0]  idle_cnt_q;
  reg         idle_seen_q;
  reg  [7:0]  rx_buf_q;
  reg         rx_rdy_q;
  reg         pe_q;
  reg         fe_q;
  reg         oe_q;
  reg         bk_q;
  reg         rx_wake_q;
  reg         rx_irq_q;

  wire [2:0]  len       = fmt_q[`FMT_LEN_HI:`FMT_LEN_LO];
  wire        addr_mode = fmt_q[`FMT_ADDR_MODE];
  wire        iso       = fmt_q[`FMT_ISO_MODE];
  wire        run       = ctl_q[`CTL_SOFT_RESET_N];
  wire [15:0] divisor   = {div_hi_q, div_lo_q}; // [R9] [R13]

  wire req     = avs_read_in | avs_write_in;
  wire wr_go   = avs_write_in & ack_q & avs_byteenable_in[0];
  wire rd_go   = avs_read_in & ack_q;
  wire wr_txb  = wr_go & (avs_address_in == `OFS_TRANSMIT_BUF);
  wire rd_rxb  = rd_go & (avs_address_in == `OFS_RECEIVE_BUF);
  wire wr_stat = wr_go & (avs_address_in == `OFS_STATUS);
  wire tx_load = run & (tx_st_q == T_IDLE) & tx_full_q & ctl_q[`CTL_TX_EN]; // [R28]
  wire rx_err  = pe_q | fe_q | oe_q | bk_q;

  // one wait state on every access, reads registered
  assign avs_waitrequest_out = req & ~ack_q;
  assign avs_readdata_out    = rdata_q;

  always @* begin
    rdata_d = 32'h0000_0000;
    case (avs_address_in)
      `OFS_FRAME_FORMAT:  rdata_d[7:0] = fmt_q;
      `OFS_PORT_CONTROL:  rdata_d[7:0] = ctl_q;
      `OFS_DIVISOR_UPPER: rdata_d[7:0] = div_hi_q;
      `OFS_DIVISOR_LOWER: rdata_d[7:0] = div_lo_q;
      `OFS_CLOCK_PIN_CTL: rdata_d[3:0] = {pinctl_q[3:2], sclk_s2_q, pinctl_q[0]}; // [R7]
      `OFS_RECEIVE_BUF:   rdata_d[7:0] = rx_buf_q;
      `OFS_STATUS: begin
        rdata_d[`ST_TX_READY]    = ~tx_full_q;
        rdata_d[`ST_TX_EMPTY]    = ~tx_full_q & (tx_st_q == T_IDLE);
        rdata_d[`ST_RX_READY]    = rx_rdy_q;
        rdata_d[`ST_RX_ERROR]    = rx_err; // [R17]
        rdata_d[`ST_PARITY_ERR]  = pe_q;
        rdata_d[`ST_FRAMING_ERR] = fe_q;
        rdata_d[`ST_OVERRUN_ERR] = oe_q;
        rdata_d[`ST_BREAK_ERR]   = bk_q;
        rdata_d[`ST_RX_WAKE]     = rx_wake_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ack_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      fmt_q    <= `RST_FRAME_FORMAT;
      ctl_q    <= `RST_PORT_CONTROL;
      div_hi_q <= `RST_DIVISOR_UPPER;
      div_lo_q <= `RST_DIVISOR_LOWER;
      pinctl_q <= `RST_CLOCK_PIN_CTL;
      tx_buf_q <= 8'h00;
    end else begin
      ack_q <= req & ~ack_q;
      if (avs_read_in & ~ack_q)
        rdata_q <= rdata_d;
      // wake bit drops when its character moves to the shift register
      if (tx_load)
        ctl_q[`CTL_TX_WAKE] <= 1'b0;
      if (wr_go) begin
        case (avs_address_in)
          `OFS_FRAME_FORMAT:  fmt_q    <= avs_writedata_in[7:0];
          `OFS_PORT_CONTROL:  ctl_q    <= avs_writedata_in[7:0]; // [R1] [R2] [R3]
          `OFS_DIVISOR_UPPER: div_hi_q <= avs_writedata_in[7:0];
          `OFS_DIVISOR_LOWER: div_lo_q <= avs_writedata_in[7:0];
          `OFS_CLOCK_PIN_CTL: pinctl_q <= avs_writedata_in[3:0];
          `OFS_TRANSMIT_BUF:  tx_buf_q <= avs_writedata_in[7:0] & len_mask(len); // [R23]
          default: ;
        endcase
      end
    end
  end

  // two-stage synchronisers for the pins
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rxd_s1_q    <= 1'b1;
      rxd_s2_q    <= 1'b1;
      rxd_prev_q  <= 1'b1;
      sclk_s1_q   <= 1'b0;
      sclk_s2_q   <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else begin
      rxd_s1_q    <= rxd_in;
      rxd_s2_q    <= rxd_s1_q;
      rxd_prev_q  <= rxd_s2_q;
      sclk_s1_q   <= sclk_pin_in;
      sclk_s2_q   <= sclk_s1_q;
      sclk_prev_q <= sclk_s2_q;
    end
  end

  // internal shift clock toggles every divisor+1 cycles: period 2*(div+1)
  wire int_tick = run & (div_cnt_q == divisor) & ~sclk_int_q; // [R11]
  // external clock must stay below mclk/10 for this edge detect
  wire ext_tick = sclk_s2_q & ~sclk_prev_q; // [R12]
  wire tick     = ctl_q[`CTL_INT_CLK] ? int_tick : ext_tick; // [R6]

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt_q  <= 16'h0000;
      sclk_int_q <= 1'b0;
      sclk_out_q <= 1'b0;
      sclk_oe_q  <= 1'b0;
    end else begin
      if (!run) begin
        div_cnt_q  <= 16'h0000;
        sclk_int_q <= 1'b0;
      end else if (div_cnt_q == divisor) begin
        div_cnt_q  <= 16'h0000;
        sclk_int_q <= ~sclk_int_q;
      end else begin
        div_cnt_q <= div_cnt_q + 16'h0001;
      end
      if (pinctl_q[`PIN_FUNCTION]) begin
        sclk_out_q <= sclk_int_q; // [R8]
        sclk_oe_q  <= ctl_q[`CTL_INT_CLK]; // [R6]
      end else begin
        sclk_out_q <= pinctl_q[`PIN_DATA_OUT]; // [R7]
        sclk_oe_q  <= pinctl_q[`PIN_DIR];
      end
    end
  end

  assign sclk_pin_out    = sclk_out_q;
  assign sclk_pin_oe_out = sclk_oe_q;

  // one bit per tick in iso, sixteen ticks in async
  wire tx_bit_end = tick & (iso | (tx_tcnt_q == `ASYNC_TICKS_LAST)); // [R4] [R5] [R10]

  always @* begin
    case (tx_st_q)
      T_START: txd_d = tx_bit_q[0]; // [R26]
      T_DATA:  txd_d = tx_shf_q[0]; // [R23]
      T_ADDR:  txd_d = wut_q; // [R24]
      T_PAR:   txd_d = tx_par_q;
      default: txd_d = 1'b1; // [R28]
    endcase
  end

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_st_q   <= T_IDLE;
      tx_tcnt_q <= 4'h0;
      tx_bit_q  <= 4'h0;
      tx_shf_q  <= 8'h00;
      wut_q     <= 1'b0;
      tx_par_q  <= 1'b0;
      tx_full_q <= 1'b0;
      txd_q     <= 1'b1;
    end else if (!run) begin
      tx_st_q   <= T_IDLE; // [R1]
      tx_tcnt_q <= 4'h0;
      tx_bit_q  <= 4'h0;
      tx_full_q <= 1'b0;
      txd_q     <= 1'b1;
    end else begin
      txd_q <= txd_d;
      if (wr_txb)
        tx_full_q <= 1'b1; // [R19]
      else if (tx_load)
        tx_full_q <= 1'b0; // [R20]
      if (tick)
        tx_tcnt_q <= tx_tcnt_q + 4'h1;
      case (tx_st_q)
        T_IDLE: begin
          if (tx_load) begin
            tx_shf_q  <= tx_buf_q; // [R20]
            wut_q     <= ctl_q[`CTL_TX_WAKE]; // [R21]
            tx_par_q  <= par_bit(tx_buf_q, len, fmt_q[`FMT_PAR_EVEN]); // [R25]
            // hold idle until a tick: full start bit
            tx_tcnt_q <= {4{addr_mode | ~ctl_q[`CTL_TX_WAKE]}};
            tx_bit_q  <= {3'h0, addr_mode | ~ctl_q[`CTL_TX_WAKE]};
            // idle-line block start: ten high bit times, character discarded
            tx_st_q   <= (~addr_mode & ctl_q[`CTL_TX_WAKE]) ? T_BLANK : T_START; // [R22]
          end
        end
        T_START: begin
          if (tx_bit_q[0])
            tx_bit_q <= {3'h0, ~tick};
          else if (tx_bit_end)
            tx_st_q <= T_DATA;
        end
        T_DATA: begin
          if (tx_bit_end) begin
            tx_shf_q <= {1'b0, tx_shf_q[7:1]};
            if (tx_bit_q[2:0] == len) begin
              tx_bit_q <= 4'h0;
              tx_st_q  <= addr_mode ? T_ADDR : (fmt_q[`FMT_PAR_EN] ? T_PAR : T_STOP); // [R24]
            end else begin
              tx_bit_q <= tx_bit_q + 4'h1;
            end
          end
        end
        T_ADDR: begin
          if (tx_bit_end)
            tx_st_q <= fmt_q[`FMT_PAR_EN] ? T_PAR : T_STOP;
        end
        T_PAR: begin
          if (tx_bit_end)
            tx_st_q <= T_STOP;
        end
        T_STOP: begin
          if (tx_bit_end) begin
            if (fmt_q[`FMT_TWO_STOP] & (tx_bit_q == 4'h0))
              tx_bit_q <= 4'h1; // [R26]
            else
              tx_st_q <= T_IDLE;
          end
        end
        T_BLANK: begin
          if (tx_bit_end) begin
            if (tx_bit_q == `BLANK_BITS_LAST)
              tx_st_q <= T_IDLE; // [R22]
            else
              tx_bit_q <= tx_bit_q + 4'h1;
          end
        end
        default: tx_st_q <= T_IDLE;
      endcase
    end
  end

  assign txd_out = txd_q;

  wire rx_line   = rxd_s2_q;
  wire rx_fall   = rxd_prev_q & ~rxd_s2_q;
  wire rx_sample = tick & (iso | (rx_tcnt_q == `ASYNC_TICKS_LAST)); // [R27]
  wire rx_done   = (rx_st_q == R_STOP) & rx_sample & ctl_q[`CTL_RX_EN];
  wire par_err   = fmt_q[`FMT_PAR_EN] & (rx_pbit_q != par_bit(rx_shf_q, len, fmt_q[`FMT_PAR_EVEN]));
  wire idle_long = idle_cnt_q >= (iso ? `IDLE_BITS_ISO : `IDLE_TICKS_ASYNC);

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_st_q     <= R_IDLE;
      rx_tcnt_q   <= 4'h0;
      rx_bit_q    <= 3'h0;
      rx_shf_q    <= 8'h00;
      rx_abit_q   <= 1'b0;
      rx_pbit_q   <= 1'b0;
      rx_zero_q   <= 1'b0;
      idle_cnt_q  <= 8'h00;
      idle_seen_q <= 1'b0;
      rx_buf_q    <= 8'h00;
      rx_rdy_q    <= 1'b0;
      pe_q        <= 1'b0;
      fe_q        <= 1'b0;
      oe_q        <= 1'b0;
      bk_q        <= 1'b0;
      rx_wake_q   <= 1'b0;
    end else if (!run) begin
      rx_st_q    <= R_IDLE; // [R1]
      rx_tcnt_q  <= 4'h0;
      idle_cnt_q <= 8'h00;
      rx_rdy_q   <= 1'b0;
      pe_q       <= 1'b0;
      fe_q       <= 1'b0;
      oe_q       <= 1'b0;
      bk_q       <= 1'b0;
      rx_wake_q  <= 1'b0;
    end else begin
      // clears first so that a same-cycle set wins
      if (rd_rxb)
        rx_rdy_q <= 1'b0;
      if (wr_stat) begin
        if (avs_writedata_in[`ST_PARITY_ERR])  pe_q <= 1'b0;
        if (avs_writedata_in[`ST_FRAMING_ERR]) fe_q <= 1'b0;
        if (avs_writedata_in[`ST_OVERRUN_ERR]) oe_q <= 1'b0;
        if (avs_writedata_in[`ST_BREAK_ERR])   bk_q <= 1'b0;
      end
      if (tick)
        rx_tcnt_q <= rx_tcnt_q + 4'h1;
      case (rx_st_q)
        R_IDLE: begin
          if (tick & rx_line & (idle_cnt_q != 8'hff))
            idle_cnt_q <= idle_cnt_q + 8'h01;
          rx_shf_q  <= 8'h00;
          rx_bit_q  <= 3'h0;
          rx_zero_q <= 1'b1;
          if (iso ? (tick & ~rx_line) : rx_fall) begin // [R14]
            idle_seen_q <= idle_long;
            idle_cnt_q  <= 8'h00;
            rx_tcnt_q   <= 4'h0;
            rx_st_q     <= iso ? R_DATA : R_START;
          end
        end
        R_START: begin
          if (tick & (rx_tcnt_q == `ASYNC_MID_TICK)) begin
            rx_tcnt_q <= 4'h0;
            rx_st_q   <= rx_line ? R_IDLE : R_DATA; // [R27]
          end
        end
        R_DATA: begin
          if (rx_sample) begin
            rx_shf_q[rx_bit_q] <= rx_line; // [R23]
            if (rx_line)
              rx_zero_q <= 1'b0;
            if (rx_bit_q == len)
              rx_st_q <= addr_mode ? R_ADDR : (fmt_q[`FMT_PAR_EN] ? R_PAR : R_STOP);
            else
              rx_bit_q <= rx_bit_q + 3'h1;
          end
        end
        R_ADDR: begin
          if (rx_sample) begin
            rx_abit_q <= rx_line; // [R18]
            if (rx_line)
              rx_zero_q <= 1'b0;
            rx_st_q <= fmt_q[`FMT_PAR_EN] ? R_PAR : R_STOP;
          end
        end
        R_PAR: begin
          if (rx_sample) begin
            rx_pbit_q <= rx_line;
            if (rx_line)
              rx_zero_q <= 1'b0;
            rx_st_q <= R_STOP;
          end
        end
        R_STOP: begin
          if (rx_sample)
            rx_st_q <= R_IDLE; // [R17]
        end
        default: rx_st_q <= R_IDLE;
      endcase
      if (rx_done) begin
        rx_buf_q  <= rx_shf_q; // [R15]
        rx_rdy_q  <= 1'b1;
        rx_wake_q <= addr_mode ? rx_abit_q : idle_seen_q; // [R18] [R24]
        if (par_err)
          pe_q <= 1'b1; // [R17]
        if (~rx_line)
          fe_q <= 1'b1;
        if (rx_rdy_q & ~rd_rxb)
          oe_q <= 1'b1;
        if (~rx_line & rx_zero_q)
          bk_q <= 1'b1;
      end
    end
  end

  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      rx_irq_q <= 1'b0;
    else
      rx_irq_q <= rx_rdy_q & ctl_q[`CTL_RX_INT_EN]; // [R16]
  end

  assign rx_irq_out = rx_irq_q;

endmodule

`default_nettype wire

// [async_isosync_serial_port_properties.sv]
/*
  port_checker: timing relations of the serial port seen at its top ports.
  Assumes the register offsets and field positions of the regs header;
  config written over the bus is mirrored here from accepted writes.
*/
`timescale 1ns/1ps
`default_nettype none
module port_checker (
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic [4:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0]  avs_byteenable_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        txd_out,
  input wire logic        sclk_pin_out,
  input wire logic        sclk_pin_oe_out,
  input wire logic        rx_irq_out
);
  logic [7:0]  ctl_q;
  logic [7:0]  ctl_p;
  logic [7:0]  pin_q;
  logic [7:0]  pin_p;
  logic [15:0] div_q;
  logic        iso_q;
  int          low_cnt;
  wire         wr_ok = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  wire         rd_ok = avs_read_in && !avs_waitrequest_out;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (sys_rst_in);

  // mirror of config, one cycle delayed copies for settled checks
  always @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctl_q <= 8'h00;
      ctl_p <= 8'h00;
      pin_q <= 8'h00;
      pin_p <= 8'h00;
      div_q <= 16'h0000;
      iso_q <= 1'b0;
      low_cnt <= 0;
    end else begin
      ctl_p <= ctl_q;
      pin_p <= pin_q;
      low_cnt <= txd_out ? 0 : low_cnt + 1;
      if (wr_ok) begin
        case (avs_address_in)
          5'h00: iso_q <= avs_writedata_in[4];
          5'h04: ctl_q <= avs_writedata_in[7:0];
          5'h08: div_q[15:8] <= avs_writedata_in[7:0];
          5'h0c: div_q[7:0] <= avs_writedata_in[7:0];
          5'h10: pin_q <= avs_writedata_in[7:0];
          default: ;
        endcase
      end
    end
  end

  wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("waitrequest held past one wait cycle");
  soft_idle_a: assert property (!ctl_q[5] && !ctl_p[5] |-> txd_out)
    else $error("transmit line not high in soft reset");
  // low runs end on bit boundaries only, so their length proves the bit time
  tx_hold_a: assert property ($rose(txd_out) && ctl_q[4] && !iso_q |-> low_cnt % ((div_q + 32'd1) * 32) == 0)
    else $error("transmit bit time wrong");
  no_tx_a: assert property (!ctl_q[1] && !ctl_p[1] && $past(txd_out) |-> txd_out)
    else $error("transmit started while disabled");
  gpio_pin_a: assert property (!pin_q[3] && pin_q == pin_p |-> sclk_pin_oe_out == pin_q[0] && sclk_pin_out == pin_q[2])
    else $error("clock pin not following gpio bits");
  clk_pin_a: assert property (pin_q[3] && pin_p[3] && ctl_q[4] == ctl_p[4] |-> sclk_pin_oe_out == ctl_q[4])
    else $error("clock pin direction wrong in clock function");
  irq_en_a: assert property (rx_irq_out |-> ctl_p[6] && $past(ctl_p[5]))
    else $error("receive irq without enable");
  irq_clr_a: assert property (rd_ok && avs_address_in == 5'h18 |-> ##2 !rx_irq_out)
    else $error("receive irq stays after buffer read");
  transmit_buffer_rd_a: assert property (rd_ok && avs_address_in == 5'h14 |-> avs_readdata_out == 32'h0)
    else $error("transmit side readable");

  cover property ($rose(rx_irq_out));
  cover property (rd_ok && avs_address_in == 5'h18);
  cover property ($fell(txd_out));
endmodule

bind async_isosync_serial_port port_checker u_chk (
  .mclk_in(mclk_in),
  .sys_rst_in(sys_rst_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_writedata_in(avs_writedata_in),
  .avs_byteenable_in(avs_byteenable_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .txd_out(txd_out),
  .sclk_pin_out(sclk_pin_out),
  .sclk_pin_oe_out(sclk_pin_oe_out),
  .rx_irq_out(rx_irq_out)
);
`default_nettype wire

// [remote_port.sv]
/*
  remote_port: far-end asynchronous serial port, behavioural.
  Assumes the same clock as the port and a bit time of BIT cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_port #(
  parameter int BIT = 64
) (
  input wire logic clk_in,
  input wire logic line_in,
  output var logic line_out
);
  logic [7:0] got;
  int         n_got;

  initial begin
    line_out = 1'b1;
    n_got = 0;
  end

  // 8-bit receiver, samples mid-bit
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge clk_in);
    if (!line_in) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge clk_in);
        got[i] = line_in;
      end
      repeat (BIT) @(posedge clk_in);
      n_got++;
    end
  end

  // stop level is an argument so framing faults can be made on purpose
  task automatic send(input logic [7:0] d, input int n, input logic stop);
    line_out <= 1'b0;
    repeat (BIT) @(posedge clk_in);
    for (int i = 0; i < n; i++) begin
      line_out <= d[i];
      repeat (BIT) @(posedge clk_in);
    end
    line_out <= stop;
    repeat (BIT) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (BIT) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
/*
  testbench: register-level tests of the serial port against remote_port.
  Assumes divisor 1, so one asynchronous bit is 64 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        mclk_in;
  logic        sys_rst_in;
  logic [4:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0]  avs_byteenable_in;
  logic        sclk_pin_in;
  wire  [31:0] avs_readdata_out;
  wire         avs_waitrequest_out;
  wire         rxd;
  wire         txd;
  wire         sclk_pin_out;
  wire         sclk_pin_oe_out;
  wire         rx_irq_out;
  logic [31:0] junk;
  int          miscompares;
  int          n_checks;

  async_isosync_serial_port u_dut (
    .mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .rxd_in(rxd),
    .txd_out(txd),
    .sclk_pin_in(sclk_pin_in),
    .sclk_pin_out(sclk_pin_out),
    .sclk_pin_oe_out(sclk_pin_oe_out),
    .rx_irq_out(rx_irq_out)
  );

  remote_port #(.BIT(64)) u_peer (
    .clk_in(mclk_in),
    .line_in(txd),
    .line_out(rxd)
  );

  always #12.5 mclk_in = ~mclk_in;

  task automatic final_report;
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // holds the request until waitrequest low, then one idle edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge mclk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, 4'hf, q);
    cmp($sformatf("reg %h", a), e, q & m);
  endtask

  task automatic wait_peer(input int n);
    for (int i = 0; i < 3000 && u_peer.n_got < n; i++) @(posedge mclk_in);
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    miscompares++;
    final_report;
  end

  initial begin
    mclk_in = 1'b0;
    sys_rst_in = 1'b1;
    avs_address_in = 5'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'h0;
    sclk_pin_in = 1'b0;
    miscompares = 0;
    n_checks = 0;
    repeat (10) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    rd_chk(5'h00, 32'hff, 32'h07);
    rd_chk(5'h04, 32'hff, 32'h00);
    rd_chk(5'h1c, 32'h1ff, 32'h003);
    wr(5'h0c, 32'h01);
    rd_chk(5'h0c, 32'hff, 32'h01);
    wr(5'h04, 32'h73);
    wr(5'h14, 32'ha5);
    wr(5'h14, 32'h5a);
    rd_chk(5'h14, 32'hff, 32'h0);
    rd_chk(5'h1c, 32'h1, 32'h0);
    wait_peer(1);
    cmp("first char", 32'ha5, {24'h0, u_peer.got});
    wait_peer(2);
    cmp("second char", 32'h5a, {24'h0, u_peer.got});
    rd_chk(5'h1c, 32'h1, 32'h1);
    u_peer.send(8'h3c, 8, 1'b1);
    cmp("rx irq", 32'h1, {31'h0, rx_irq_out});
    rd_chk(5'h1c, 32'h0fc, 32'h004);
    rd_chk(5'h18, 32'hff, 32'h3c);
    rd_chk(5'h1c, 32'h004, 32'h0);
    // break with low stop, then a good frame over the unread one
    u_peer.send(8'h00, 8, 1'b0);
    u_peer.send(8'h55, 8, 1'b1);
    rd_chk(5'h1c, 32'h0fc, 32'h0ec);
    rd_chk(5'h18, 32'hff, 32'h55);
    wr(5'h1c, 32'hf0);
    rd_chk(5'h1c, 32'h0f0, 32'h0);
    u_peer.send(8'h3c, 8, 1'b1);
    wr(5'h04, 32'h53);
    rd_chk(5'h1c, 32'h1ff, 32'h003);
    wr(5'h00, 32'h64);
    wr(5'h04, 32'h73);
    acc(1'b1, 5'h00, 32'h00, 4'h0, junk);
    rd_chk(5'h00, 32'hff, 32'h64);
    u_peer.send(8'h35, 6, 1'b1);
    rd_chk(5'h18, 32'hff, 32'h15);
    rd_chk(5'h1c, 32'h010, 32'h0);
    u_peer.send(8'h15, 6, 1'b1);
    rd_chk(5'h1c, 32'h018, 32'h018);
    wr(5'h10, 32'h05);
    sclk_pin_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    cmp("pin oe", 32'h1, {31'h0, sclk_pin_oe_out});
    cmp("pin out", 32'h1, {31'h0, sclk_pin_out});
    rd_chk(5'h10, 32'h2, 32'h2);
    wr(5'h10, 32'h08);
    repeat (2) @(posedge mclk_in);
    cmp("clock pin oe", 32'h1, {31'h0, sclk_pin_oe_out});
    wr(5'h04, 32'h63);
    repeat (2) @(posedge mclk_in);
    cmp("ext clock oe", 32'h0, {31'h0, sclk_pin_oe_out});
    final_report;
  end
endmodule
`default_nettype wire
